/* bench/arc_core_checker.sv */
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module arc_core_checker #(
  parameter SYM_DIV = 16'd1600
) (
  input wire       i_clk,
  input wire       i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire [7:0] i_tx_octet1,
  input wire       i_cca_done,
  input wire       i_cca_idle,
  input wire       i_tx_done,
  input wire       i_rx_end,
  input wire       i_rx_ack_req,
  input wire       i_rx_fcs_ok,
  input wire       o_cca_start,
  input wire       o_tx_start,
  input wire       o_ack_tx_start,
  input wire       o_rx_on,
  input wire       o_buf_wr_block,
  input wire       o_frame_done_irq
);
  // Tick is free running, so every window allows one symbol of slack
  localparam int AL = 11 * SYM_DIV;
  localparam int AH = 13 * SYM_DIV + 4;
  localparam int SL = SYM_DIV;
  localparam int SH = 4 * SYM_DIV + 4;
  localparam int WB = 121 * SYM_DIV + 8;
  localparam int WQ = 55 * SYM_DIV + 8;
  reg [2:0]  csma;
  reg        shrt, oq, ok;
  reg [19:0] wt;
  wire       ack_in = i_rx_end && i_rx_ack_req && i_rx_fcs_ok
               && !o_buf_wr_block;
  // Shadow of the control bits that the timing depends on
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      csma <= 3'h4;
      {shrt, oq, ok} <= 3'h0;
      wt <= 20'h0;
    end else begin
      if (i_wr && i_addr == 8'h2c)
        csma <= i_wdata[3:1];
      if (i_wr && i_addr == 8'h17)
        shrt <= i_wdata[2];
      if (i_wr && i_addr == 8'h30)
        oq <= i_wdata[1];
      if (o_tx_start)
        ok <= 1'b0;
      else if (i_cca_done && i_cca_idle)
        ok <= 1'b1;
      wt <= (o_rx_on && o_buf_wr_block) ? wt + 20'h1 : 20'h0;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  tx_after_cca_a: assert property (
    o_tx_start |-> ok || csma == 3'h7) else $error("send without idle");
  done_no_ack_a: assert property (
    i_tx_done && o_buf_wr_block && !i_tx_octet1[5] |-> ##[1:3]
    o_frame_done_irq) else $error("no done after send");
  listen_after_a: assert property (
    i_tx_done && o_buf_wr_block && i_tx_octet1[5] |-> ##[1:3] o_rx_on)
    else $error("receiver not on");
  busy_blocks_a: assert property (
    o_cca_start || o_tx_start |-> o_buf_wr_block) else $error("unblocked");
  idle_at_done_a: assert property (
    $fell(o_buf_wr_block) |-> o_frame_done_irq || $past(o_frame_done_irq))
    else $error("busy ended without done");
  wait_bound_a: assert property (
    wt <= (oq ? WQ : WB)) else $error("reply wait too long");
  ack_turn_a: assert property (
    ack_in && !shrt |-> ##[AL:AH] o_ack_tx_start) else $error("ack late");
  ack_short_a: assert property (
    ack_in && shrt |-> ##[SL:SH] o_ack_tx_start) else $error("short ack");
  cover property (o_ack_tx_start);
  cover property (o_cca_start ##[1:300] o_tx_start);
  cover property (wt == 20'd100);
endmodule // arc_core_checker

bind arc_core arc_core_checker #(.SYM_DIV(SYM_DIV)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_tx_octet1(i_tx_octet1), .i_cca_done(i_cca_done),
  .i_cca_idle(i_cca_idle), .i_tx_done(i_tx_done), .i_rx_end(i_rx_end),
  .i_rx_ack_req(i_rx_ack_req), .i_rx_fcs_ok(i_rx_fcs_ok),
  .o_cca_start(o_cca_start), .o_tx_start(o_tx_start),
  .o_ack_tx_start(o_ack_tx_start), .o_rx_on(o_rx_on),
  .o_buf_wr_block(o_buf_wr_block), .o_frame_done_irq(o_frame_done_irq));

/* bench/arc_radio_model.sv */
`timescale 1ns/1ps
// ----------
// Far side: channel, air and remote node
// ----------
module arc_radio_model #(
  parameter SYM_DIV = 4
) (
  input  wire       i_clk,
  input  wire       i_cca_start,
  input  wire       i_tx_start,
  input  wire       i_rx_on,
  input  wire       i_clr,
  input  wire       i_send,
  input  wire [3:0] i_busy_n,
  input  wire [1:0] i_ack_mode,
  input  wire [7:0] i_seq,
  input  wire [7:0] i_dly,
  output reg        o_cca_done = 1'b0,
  output reg        o_cca_idle = 1'b0,
  output reg        o_tx_done = 1'b0,
  output reg        o_sfd = 1'b0,
  output reg        o_rx_end = 1'b0,
  output reg        o_rx_ack_req = 1'b0,
  output reg        o_rx_is_ack = 1'b0,
  output reg        o_rx_fcs_ok = 1'b0,
  output reg        o_rx_pending = 1'b0,
  output reg  [7:0] o_rx_seq = 8'h00
);
  integer n_cca = 0;
  // Fields invert after the end pulse so stale values never look valid
  task frame(input [7:0] s, input a, input q, input p);
    o_sfd <= 1'b1;
    @(posedge i_clk);
    o_sfd <= 1'b0;
    repeat (i_dly) @(posedge i_clk);
    o_rx_end <= 1'b1;
    {o_rx_seq, o_rx_is_ack, o_rx_ack_req, o_rx_pending} <= {s, a, q, p};
    o_rx_fcs_ok <= 1'b1;
    @(posedge i_clk);
    o_rx_end <= 1'b0;
    {o_rx_seq, o_rx_is_ack, o_rx_ack_req, o_rx_pending} <= ~{s, a, q, p};
    o_rx_fcs_ok <= 1'b0;
  endtask
  // eight-symbol check, busy a set number of times
  always @(posedge i_clk) begin
    if (i_cca_start) begin
      repeat (8 * SYM_DIV - 1) @(posedge i_clk);
      o_cca_done <= 1'b1;
      o_cca_idle <= (n_cca >= i_busy_n);
      n_cca = n_cca + 1;
      @(posedge i_clk);
      o_cca_done <= 1'b0;
      o_cca_idle <= ~o_cca_idle;
    end
  end
  // Air time of a sent frame
  always @(posedge i_clk) begin
    if (i_tx_start) begin
      repeat (20) @(posedge i_clk);
      o_tx_done <= 1'b1;
      @(posedge i_clk);
      o_tx_done <= 1'b0;
    end
  end
  // reply, a wrong sequence number first in mode 3
  always @(posedge i_rx_on) begin
    if (i_ack_mode != 2'h0) begin
      if (i_ack_mode == 2'h3)
        frame(~i_seq, 1'b1, 1'b0, 1'b0);
      frame(i_seq, 1'b1, 1'b0, i_ack_mode == 2'h2);
    end
  end
  // data frame asking for a reply
  always @(posedge i_send) frame(8'h33, 1'b0, 1'b1, 1'b0);
  always @(posedge i_clr) n_cca = 0;
endmodule // arc_radio_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
// ----------
// Bench
// ----------
module tb_top;
  localparam SD = 4;
  localparam [7:0] SEQ = 8'h5a;
  logic       i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_tx_octet1 = 8'h00, d;
  logic       i_sleep_trigger_pin = 1'b0, clr = 1'b0, send = 1'b0;
  logic [3:0] busy_n = 4'h0;
  logic [1:0] ack_mode = 2'h0;
  logic [7:0] dly = 8'd40;
  wire  [7:0] o_rdata, i_rx_seq;
  wire        i_sfd, i_rx_end, i_rx_ack_req, i_rx_is_ack, i_rx_fcs_ok;
  wire        i_rx_pending, i_cca_done, i_cca_idle, i_tx_done;
  wire        o_cca_start, o_tx_start, o_ack_tx_start, o_rx_on;
  wire        o_buf_wr_block, o_frame_done_irq;
  integer     mismatches = 0, comparisons = 0, lat = 0;
  integer     n_cca = 0, n_tx = 0, n_irq = 0, rxw = 0, on_len = 0;
  arc_core #(.SYM_DIV(16'd4)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sfd(i_sfd),
    .i_sleep_trigger_pin(i_sleep_trigger_pin), .i_rx_end(i_rx_end),
    .i_rx_ack_req(i_rx_ack_req), .i_rx_is_ack(i_rx_is_ack),
    .i_rx_fcs_ok(i_rx_fcs_ok), .i_rx_seq(i_rx_seq), .i_tx_seq(SEQ),
    .i_rx_pending(i_rx_pending), .i_tx_octet1(i_tx_octet1),
    .i_cca_done(i_cca_done), .i_cca_idle(i_cca_idle),
    .i_tx_done(i_tx_done), .o_cca_start(o_cca_start),
    .o_tx_start(o_tx_start), .o_ack_tx_start(o_ack_tx_start),
    .o_rx_on(o_rx_on), .o_buf_wr_block(o_buf_wr_block),
    .o_frame_done_irq(o_frame_done_irq));
  arc_radio_model #(.SYM_DIV(SD)) far (
    .i_clk(i_clk), .i_cca_start(o_cca_start), .i_rx_on(o_rx_on),
    .i_tx_start(o_tx_start | o_ack_tx_start), .i_clr(clr), .i_send(send),
    .i_busy_n(busy_n), .i_ack_mode(ack_mode), .i_seq(SEQ), .i_dly(dly),
    .o_cca_done(i_cca_done), .o_cca_idle(i_cca_idle),
    .o_tx_done(i_tx_done), .o_sfd(i_sfd), .o_rx_end(i_rx_end),
    .o_rx_ack_req(i_rx_ack_req), .o_rx_is_ack(i_rx_is_ack),
    .o_rx_fcs_ok(i_rx_fcs_ok), .o_rx_pending(i_rx_pending),
    .o_rx_seq(i_rx_seq));
  initial forever #5 i_clk = ~i_clk;
  // Event counts and length of the last receive window
  always @(posedge i_clk) begin
    n_cca <= n_cca + o_cca_start;
    n_tx <= n_tx + o_tx_start;
    n_irq <= n_irq + o_frame_done_irq;
    rxw <= o_rx_on ? rxw + 1 : 0;
    if (!o_rx_on && rxw != 0)
      on_len <= rxw;
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task rd(input [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    // Read data stand between the two edges; sample mid-cycle
    @(negedge i_clk);
    d = o_rdata;
    @(posedge i_clk);
  endtask
  function logic sel(input integer s);
    case (s)
      0: sel = o_frame_done_irq;
      1: sel = i_rx_end;
      default: sel = o_ack_tx_start;
    endcase
  endfunction
  // Bounded wait; the count doubles as a latency figure
  task wait_for(input integer s);
    lat = 0;
    while (sel(s) !== 1'b1 && lat < 5000) begin
      @(posedge i_clk);
      lat = lat + 1;
    end
    chk("wait", lat < 5000, 1'b1);
  endtask
  task ack_test(input integer lo, input integer hi);
    integer q;
    q = n_irq;
    send <= 1'b1;
    @(posedge i_clk);
    send <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd(8'h01);
    chk("rx busy", d, 8'h11);
    wait_for(1);
    wait_for(2);
    chk("ack delay", lat >= lo && lat <= hi, 1'b1);
    repeat (30) @(posedge i_clk);
    chk("rx done", n_irq - q, 1);
  endtask
  task run(input [7:0] o, input [3:0] b, input [1:0] m, input g,
           input [2:0] r, input integer nc, input integer nt);
    integer c, x, q;
    c = n_cca;
    x = n_tx;
    q = n_irq;
    i_tx_octet1 <= o;
    busy_n <= b;
    ack_mode <= m;
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    if (g)
      i_sleep_trigger_pin <= 1'b1;
    else
      wr(8'h02, 8'h02);
    repeat (3) @(posedge i_clk);
    chk("blocked", o_buf_wr_block, 1'b1);
    rd(8'h01);
    chk("busy st", d, 8'h12);
    rd(8'h02);
    chk("res inv", d[7:5], 3'h7);
    wait_for(0);
    i_sleep_trigger_pin <= 1'b0;
    repeat (2) @(posedge i_clk);
    rd(8'h01);
    chk("idle st", d, 8'h19);
    rd(8'h02);
    chk("result", d[7:5], r);
    chk("cca cnt", n_cca - c, nc);
    chk("tx cnt", n_tx - x, nt);
    chk("done cnt", n_irq - q, 1);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches = mismatches + 1;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(8'h01);
    chk("reset st", d, 8'h08);
    rd(8'h02);
    chk("reset res", d[7:5], 3'h7);
    rd(8'h2c);
    chk("retry lim", d[7:1], 7'h1c);
    rd(8'h55);
    chk("unmapped", d, 8'h00);
    wr(8'h02, 8'h16);
    rd(8'h01);
    chk("listen", d, 8'h16);
    ack_test(11 * SD, 13 * SD + 4);
    wr(8'h17, 8'h04);
    ack_test(SD, 4 * SD + 4);
    wr(8'h02, 8'h19);
    rd(8'h01);
    chk("retry idle", d, 8'h19);
    run(8'h01, 0, 0, 1, 0, 1, 1);
    run(8'h21, 0, 1, 0, 0, 1, 1);
    run(8'h21, 2, 2, 1, 1, 3, 1);
    run(8'h21, 0, 3, 1, 0, 1, 1);
    run(8'h01, 15, 0, 0, 3, 5, 0);
    run(8'h01, 15, 0, 1, 3, 5, 0);
    run(8'h21, 0, 0, 1, 5, 4, 4);
    chk("bpsk wait", on_len >= 119 * SD, 1'b1);
    wr(8'h30, 8'h02);
    wr(8'h2c, 8'h08);
    run(8'h21, 0, 0, 1, 5, 1, 1);
    lat = on_len - 53 * SD;
    chk("oqpsk wait", lat >= 0 && lat <= 2 * SD + 8, 1'b1);
    dly <= 8'd150;
    run(8'h21, 0, 1, 1, 0, 1, 1);
    wr(8'h2c, 8'h3e);
    run(8'h21, 15, 0, 1, 5, 0, 1);
    finish_test;
  end
endmodule // tb_top

/* core/arc_core.v */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// RQ1: Listening state becomes busy receive state on start-of-frame detect.
// RQ2: Requested ACK sent 12 symbols after frame end; done pulse follows. Code pulses done at frame end, before the ACK.
// RQ3: Short ACK delay bit set gives two or three symbol delay.
// RQ4: Host enters retry mode by writing retry command to state field.
// RQ5: Start comes from trigger pin rising edge or start command.
// RQ6: Clear channel check must report idle before frame is sent.
// RQ7: Busy channel retried up to limit; then abort with code 3.
// RQ8: Bit 5 of first frame octet tells whether reply is expected.
// RQ9: No reply wanted: done right after send, code 0.
// RQ10: Reply wanted: listen, accept only matching sequence with good FCS.
// RQ11: Valid reply ends transaction with code 0, or 1 if pending.
// RQ12: Timeout repeats whole attempt; past frame retry limit gives code 5.
// RQ13: Frame buffer is never written during the transaction.
// RQ14: Other frames received while waiting are dropped silently.
// RQ15: Result valid from done pulse until next send; 7 means invalid.
// RQ16: Channel retry limit 7 sends once at once without channel check.
// RQ17: Reply wait is 120 symbols in BPSK, 54 in O-QPSK.
// RQ18: Wait equals backoff plus turnaround plus header plus six octets.
// RQ19: All symbol counts use the header symbol tick of active mode.
// RQ20: Host loads frame buffer before starting a transmission.
// RQ21: Busy retry state shown during whole transaction, then idle state.
// RQ22: Retry counters clear at each new start event.
module arc_core #(
  parameter SYM_DIV = 16'd1600
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_sleep_trigger_pin,
  input  wire       i_sfd,
  input  wire       i_rx_end,
  input  wire       i_rx_ack_req,
  input  wire       i_rx_is_ack,
  input  wire       i_rx_fcs_ok,
  input  wire [7:0] i_rx_seq,
  input  wire       i_rx_pending,
  input  wire [7:0] i_tx_octet1,
  input  wire [7:0] i_tx_seq,
  input  wire       i_cca_done,
  input  wire       i_cca_idle,
  input  wire       i_tx_done,
  output reg        o_cca_start,
  output reg        o_tx_start,
  output reg        o_ack_tx_start,
  output reg        o_rx_on,
  output wire       o_buf_wr_block,
  output reg        o_frame_done_irq
);
`include "arc_defines.vh"
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam S_IDLE  = 4'd0;
  localparam S_LSTN  = 4'd1;
  localparam S_ABUSY = 4'd2;
  localparam S_ADLY  = 4'd3;
  localparam S_ATX   = 4'd4;
  localparam S_RIDLE = 4'd5;
  localparam S_CCA   = 4'd6;
  localparam S_TX    = 4'd7;
  localparam S_WAIT  = 4'd8;

  reg [3:0]  state;
  reg [4:0]  state_cmd;
  reg        short_ack_delay_bit;
  reg [2:0]  csma_lim;
  reg [3:0]  frame_lim;
  reg [1:0]  phy_mode;
  reg [2:0]  transaction_result_code;
  reg [2:0]  csma_cnt;
  reg [3:0]  frame_cnt;
  reg [15:0] div_cnt;
  reg [7:0]  sym_cnt;
  reg        trig_d;
  reg        ack_want;

  wire sym_tick = (div_cnt == 16'd0);
  wire bpsk = ~phy_mode[1];
  wire fast = phy_mode[0];
  wire start_ev = (i_sleep_trigger_pin & ~trig_d) |
    (i_wr & (i_addr == `ARC_REG_STATE_CTRL) &
     (i_wdata[4:0] == `ARC_CMD_TX_START));
  wire no_csma = (csma_lim == `ARC_CSMA_NO_CCA);
  // Symbol counts held at the counter's own width
  localparam [7:0] WAIT_BPSK  = `ARC_TIMEOUT_BPSK;
  localparam [7:0] WAIT_OQPSK = `ARC_TIMEOUT_OQPSK;
  localparam [7:0] ACK_STD    = `ARC_ACK_TURN_SYM;
  localparam [7:0] ACK_FAST   = `ARC_ACK_SHORT_FAST;
  localparam [7:0] ACK_SLOW   = `ARC_ACK_SHORT_SLOW;
  // RQ17 RQ18 mode-dependent wait
  wire [7:0] wait_sym = bpsk ? WAIT_BPSK : WAIT_OQPSK;
  // RQ2 RQ3 ACK turnaround choice
  wire [7:0] ack_sym = !short_ack_delay_bit ? ACK_STD :
    (fast ? ACK_FAST : ACK_SLOW);
  // RQ10 RQ14 only matching good ACK counts
  wire ack_ok = i_rx_end & i_rx_is_ack & i_rx_fcs_ok &
    (i_rx_seq == i_tx_seq);

  // RQ13 buffer locked in the busy retry states
  assign o_buf_wr_block = (state >= S_CCA);

  // ----------------------------------------------------------------
  // Symbol tick from header symbol rate
  // ----------------------------------------------------------------
  // RQ19 header symbol period
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 16'd0;
      trig_d  <= 1'b0;
    end else begin
      div_cnt <= sym_tick ? SYM_DIV - 16'd1 : div_cnt - 16'd1;
      trig_d  <= i_sleep_trigger_pin;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_cmd           <= `ARC_CMD_NOP;
      short_ack_delay_bit <= 1'b0;
      csma_lim            <= 3'h4;
      frame_lim           <= 4'h3;
      phy_mode            <= 2'h0;
    end else if (i_wr) begin
      case (i_addr)
        `ARC_REG_STATE_CTRL: state_cmd <= i_wdata[4:0];
        `ARC_REG_EXT_CTRL_B:
          short_ack_delay_bit <= i_wdata[`ARC_SHORT_ACK_BIT];
        `ARC_REG_EXT_CTRL_A: begin
          frame_lim <= i_wdata[7:4];
          csma_lim  <= i_wdata[3:1];
        end
        `ARC_REG_PHY_MODE: phy_mode <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle later; unmapped reads zero
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ARC_REG_RADIO_STATE: begin
          // RQ21 busy or idle retry state
          case (state)
            S_LSTN:  o_rdata <= {3'h0, `ARC_ST_AACK_LISTEN};
            S_ABUSY, S_ADLY, S_ATX:
                     o_rdata <= {3'h0, `ARC_ST_AACK_BUSY};
            S_RIDLE: o_rdata <= {3'h0, `ARC_ST_ARET_IDLE};
            S_CCA, S_TX, S_WAIT:
                     o_rdata <= {3'h0, `ARC_ST_ARET_BUSY};
            default: o_rdata <= {3'h0, `ARC_ST_IDLE};
          endcase
        end
        // RQ15 result readable in top bits
        `ARC_REG_STATE_CTRL: o_rdata <= {transaction_result_code, state_cmd};
        `ARC_REG_EXT_CTRL_B:
          o_rdata <= {5'h0, short_ack_delay_bit, 2'h0};
        `ARC_REG_EXT_CTRL_A: o_rdata <= {frame_lim, csma_lim, 1'b0};
        `ARC_REG_PHY_MODE:   o_rdata <= {6'h0, phy_mode};
        default:             o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Main state machine
  // ----------------------------------------------------------------
  // Strobes are one-cycle pulses; sym_cnt counts symbol ticks
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state                   <= S_IDLE;
      transaction_result_code <= `ARC_RES_INVALID;
      csma_cnt                <= 3'h0;
      frame_cnt               <= 4'h0;
      sym_cnt                 <= 8'h00;
      ack_want                <= 1'b0;
      o_cca_start             <= 1'b0;
      o_tx_start              <= 1'b0;
      o_ack_tx_start          <= 1'b0;
      o_rx_on                 <= 1'b0;
      o_frame_done_irq        <= 1'b0;
    end else begin
      o_cca_start      <= 1'b0;
      o_tx_start       <= 1'b0;
      o_ack_tx_start   <= 1'b0;
      o_frame_done_irq <= 1'b0;
      case (state)
        S_IDLE, S_LSTN, S_RIDLE: begin
          o_rx_on <= (state == S_LSTN);
          // RQ4 mode commands
          if (i_wr && i_addr == `ARC_REG_STATE_CTRL &&
              i_wdata[4:0] == `ARC_CMD_ARET_ON)
            state <= S_RIDLE;
          else if (i_wr && i_addr == `ARC_REG_STATE_CTRL &&
                   i_wdata[4:0] == `ARC_CMD_AACK_ON)
            state <= S_LSTN;
          // RQ1 SFD goes busy
          else if (state == S_LSTN && i_sfd)
            state <= S_ABUSY;
          // RQ5 either start event
          else if (state == S_RIDLE && start_ev) begin
            // RQ22 counters cleared
            csma_cnt                <= 3'h0;
            frame_cnt               <= 4'h0;
            transaction_result_code <= `ARC_RES_INVALID;
            o_rx_on                 <= 1'b0;
            // RQ16 skip channel check
            if (no_csma) begin
              o_tx_start <= 1'b1;
              state      <= S_TX;
            end else begin
              o_cca_start <= 1'b1;
              state       <= S_CCA;
            end
          end
        end
        S_ABUSY: begin
          if (i_rx_end) begin
            if (i_rx_fcs_ok)
              o_frame_done_irq <= 1'b1;
            if (i_rx_fcs_ok && i_rx_ack_req) begin
              transaction_result_code <= `ARC_RES_WAIT_REPLY;
              sym_cnt <= 8'h00;
              state   <= S_ADLY;
            end else begin
              state <= S_LSTN;
            end
          end
        end
        S_ADLY: begin
          // RQ2 RQ3 delay then send ACK
          if (sym_tick)
            sym_cnt <= sym_cnt + 8'h01;
          if (sym_tick && sym_cnt + 8'h01 >= ack_sym) begin
            o_ack_tx_start <= 1'b1;
            o_rx_on        <= 1'b0;
            state          <= S_ATX;
          end
        end
        S_ATX: begin
          if (i_tx_done) begin
            transaction_result_code <= `ARC_RES_OK;
            state <= S_LSTN;
          end
        end
        S_CCA: begin
          // RQ6 send only on idle channel
          if (i_cca_done && i_cca_idle) begin
            o_tx_start <= 1'b1;
            state      <= S_TX;
          end else if (i_cca_done) begin
            // RQ7 channel retry and abort
            if (csma_cnt >= csma_lim) begin
              transaction_result_code <= `ARC_RES_CHAN_BUSY;
              o_frame_done_irq        <= 1'b1;
              state                   <= S_RIDLE;
            end else begin
              csma_cnt    <= csma_cnt + 3'h1;
              o_cca_start <= 1'b1;
            end
          end
        end
        S_TX: begin
          // RQ8 sample request bit
          ack_want <= i_tx_octet1[`ARC_ACK_REQ_BIT];
          if (i_tx_done) begin
            if (ack_want) begin
              // RQ10 listen for reply
              o_rx_on <= 1'b1;
              sym_cnt <= 8'h00;
              state   <= S_WAIT;
            end else begin
              // RQ9 done at once
              transaction_result_code <= `ARC_RES_OK;
              o_frame_done_irq        <= 1'b1;
              state                   <= S_RIDLE;
            end
          end
        end
        S_WAIT: begin
          if (sym_tick)
            sym_cnt <= sym_cnt + 8'h01;
          // RQ11 valid reply result
          if (ack_ok) begin
            transaction_result_code <= i_rx_pending ?
              `ARC_RES_OK_PEND : `ARC_RES_OK;
            o_frame_done_irq <= 1'b1;
            o_rx_on          <= 1'b0;
            state            <= S_RIDLE;
          end else if (sym_tick && sym_cnt + 8'h01 >= wait_sym) begin
            // RQ12 repeat or give up
            o_rx_on <= 1'b0;
            if (no_csma || frame_cnt >= frame_lim) begin
              transaction_result_code <= `ARC_RES_NO_ACK;
              o_frame_done_irq        <= 1'b1;
              state                   <= S_RIDLE;
            end else begin
              frame_cnt   <= frame_cnt + 4'h1;
              csma_cnt    <= 3'h0;
              o_cca_start <= 1'b1;
              state       <= S_CCA;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Usage notes
  // ----------------------------------------------------------------
  // Symbol timing
  // The tick is free running, not restarted per frame.
  // So every symbol delay may come up to one symbol early.
  // Restarting it would cost a compare per event; not worth it.
  // SYM_DIV must match the header symbol rate of the mode.
  // Changing the mode register mid-transaction changes the wait.
  // Hosts should only touch it while in an idle state.
  //
  // Auto-acknowledge side
  // Only good-FCS frames raise the done pulse.
  // A frame without a reply request goes straight back to listen.
  // The reply start pulse tells the radio to send the ACK.
  // The listen state is only left by a start-of-frame or a new mode command.
  // A start-of-frame during the reply delay is ignored.
  //
  // Retry-transmit side
  // A start event outside the retry idle state is dropped.
  // A pin level held high gives only one start.
  // The command path and the pin path may coincide harmlessly.
  // The request bit is latched while the frame is on air.
  // Its value at the end of sending decides the wait.
  // Replies with a wrong number or bad FCS are ignored.
  // Ignored frames do not extend or restart the wait.
  // A retry starts again from the channel check.
  // Each retry restores the full channel-check allowance.
  // Limit 7 skips the check and forbids any frame retry.
  //
  // Result code
  // Seven is loaded at every start, so stale codes vanish.
  // The code then holds until the next start event or a received frame that asks for a reply.
  // Reads of the code in the busy retry state return seven.
  // The reply-wait code only appears on the receive side.
  //
  // Frame buffer
  // The block never writes the buffer itself.
  // The lock output tells the buffer port to refuse writes.
  // It is combinational so it acts in the same cycle.
  // It covers channel check, send and reply wait.
  //
  // Register port
  // Reads return data one cycle later and zero otherwise.
  // Zero when idle lets several slaves be ORed together.
  // Unmapped writes are ignored without any error.
  // The command field keeps the last value written.
  //
  // Limitations
  // No backoff exponent; a busy channel retries at once.
  // No address filtering; the radio front end must do it.
  // No slotted reply trigger and no clockless listen.
  // No interrupt mask; the done pulse is always given.
  // Counters saturate by the limit compare, never wrap.

endmodule // arc_core

/* core/arc_defines.vh */
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ARC_REG_RADIO_STATE   8'h01
`define ARC_REG_STATE_CTRL    8'h02
`define ARC_REG_EXT_CTRL_B    8'h17
`define ARC_REG_EXT_CTRL_A    8'h2c
`define ARC_REG_PHY_MODE      8'h30
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define ARC_SHORT_ACK_BIT     2
`define ARC_ACK_REQ_BIT       5
`define ARC_CSMA_NO_CCA       3'h7
// ----------------------------------------------------------------
// Commands and states (5-bit field)
// ----------------------------------------------------------------
`define ARC_CMD_NOP           5'h00
`define ARC_CMD_TX_START      5'h02
`define ARC_CMD_AACK_ON       5'h16
`define ARC_CMD_ARET_ON       5'h19
`define ARC_ST_IDLE           5'h08
`define ARC_ST_AACK_LISTEN    5'h16
`define ARC_ST_AACK_BUSY      5'h11
`define ARC_ST_ARET_IDLE      5'h19
`define ARC_ST_ARET_BUSY      5'h12
// ----------------------------------------------------------------
// Result codes
// ----------------------------------------------------------------
`define ARC_RES_OK            3'h0
`define ARC_RES_OK_PEND       3'h1
`define ARC_RES_WAIT_REPLY    3'h2
`define ARC_RES_CHAN_BUSY     3'h3
`define ARC_RES_NO_ACK        3'h5
`define ARC_RES_INVALID       3'h7
// ----------------------------------------------------------------
// Timing in symbol periods
// ----------------------------------------------------------------
`define ARC_ACK_TURN_SYM      12
`define ARC_ACK_SHORT_SLOW    2
`define ARC_ACK_SHORT_FAST    3
`define ARC_TIMEOUT_BPSK      120
`define ARC_TIMEOUT_OQPSK     54
`define ARC_CCA_SYM           8
`endif
